// ### bench/rds_probe.sv
// External reset source and test probe model for the reset block.
// Assumes the block's clk; every pin changes at a falling edge.
`timescale 1ns/1ps
`default_nettype none

module rds_probe (
  input  wire logic                clk,
  input  wire logic                tdo,
  output var  logic                ext_rst_n,
  output var  logic                tap_function_select,
  output var  logic                osc_stable,
  output var  logic                flash_stable,
  output var  rds_pkg::rds_jtag_s  jtag,
  output var  logic                dbg_tdo,
  output var  logic                dbg_tdo_oe
);
  initial begin
    ext_rst_n = 1'b1;
    tap_function_select = 1'b1;
    osc_stable = 1'b1;
    flash_stable = 1'b1;
    jtag = 4'h1;
    dbg_tdo = 1'b0;
    dbg_tdo_oe = 1'b0;
  end

  // Select level is held all through the reset pulse
  task automatic ext_reset(input logic sel, input int cycles);
    @(negedge clk);
    tap_function_select = sel;
    ext_rst_n = 1'b0;
    repeat (cycles) @(negedge clk);
    ext_rst_n = 1'b1;
  endtask

  // One-cycle loss of either stable report
  task automatic glitch(input logic osc, input logic flash);
    @(negedge clk);
    osc_stable = ~osc;
    flash_stable = ~flash;
    @(negedge clk);
    osc_stable = 1'b1;
    flash_stable = 1'b1;
  endtask

  task automatic set_pins(input logic [3:0] pins, input logic d);
    @(negedge clk);
    jtag = pins;
    dbg_tdo = d;
    dbg_tdo_oe = 1'b1;
  endtask

  // Test clock stands low between bits; tdo taken before the rise
  task automatic tck_bit(input logic tms, input logic tdi,
                         output logic got);
    @(negedge clk);
    jtag.tms = tms;
    jtag.tdi = tdi;
    repeat (4) @(negedge clk);
    got = tdo;
    jtag.tck = 1'b1;
    repeat (4) @(negedge clk);
    jtag.tck = 1'b0;
    jtag.tdi = ~tdi;
  endtask
endmodule

`default_nettype wire

// ### bench/rds_top_test.sv
// Self-checking bench for the reset and debug-select block.
// Assumes the probe model drives all pins of the far side.
`timescale 1ns/1ps
`default_nettype none
`include "rds_defines.svh"

module rds_top_test;
  logic                  clk;
  logic                  nrst;
  logic                  ce;
  rds_pkg::rds_periph_t  periph_rst_req;
  logic                  ext_rst_n;
  logic                  osc_stable;
  logic                  flash_stable;
  logic                  tap_function_select;
  rds_pkg::rds_jtag_s    jtag;
  logic                  dbg_tdo;
  logic                  dbg_tdo_oe;
  logic                  sys_rst_n;
  rds_pkg::rds_periph_t  periph_rst_n;
  rds_pkg::rds_cause_s   rst_cause;
  rds_pkg::rds_clk_src_e system_base_clock;
  logic                  debug_mode;
  rds_pkg::rds_jtag_s    dbg_jtag;
  logic                  tdo;
  logic                  tdo_oe;
  int                    bad_count;
  int                    tests_run;
  int                    cycles;

  rds_top DUT (.clk(clk), .nrst(nrst), .ce(ce), .ext_rst_n(ext_rst_n),
    .osc_stable(osc_stable), .flash_stable(flash_stable),
    .tap_function_select(tap_function_select),
    .periph_rst_req(periph_rst_req), .jtag(jtag), .dbg_tdo(dbg_tdo),
    .dbg_tdo_oe(dbg_tdo_oe), .bscan_in(8'h3C), .sys_rst_n(sys_rst_n),
    .periph_rst_n(periph_rst_n), .rst_cause(rst_cause),
    .system_base_clock(system_base_clock), .debug_mode(debug_mode),
    .dbg_jtag(dbg_jtag), .tdo(tdo), .tdo_oe(tdo_oe));

  rds_probe probe (.clk(clk), .tdo(tdo), .ext_rst_n(ext_rst_n),
    .tap_function_select(tap_function_select), .osc_stable(osc_stable),
    .flash_stable(flash_stable), .jtag(jtag), .dbg_tdo(dbg_tdo),
    .dbg_tdo_oe(dbg_tdo_oe));

  initial clk = 1'b0;
  always #2 clk = ~clk;

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      bad_count = bad_count + 1;
      stop_test();
    end
  end

  task automatic check(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
    tests_run = tests_run + 1;
    if (got !== exp) begin
      bad_count = bad_count + 1;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // Full external reset; optional stability loss during the wait
  task automatic run_reset(input logic sel, input logic g_osc,
                           input logic g_fl, input logic [2:0] cause);
    int i;
    probe.ext_reset(sel, 3);
    check("sys_rst_n held", 32'h0, sys_rst_n);
    check("periph held", 32'h0, periph_rst_n);
    check("clock source", {31'h0, ~sel},
          system_base_clock);
    if (g_osc || g_fl) begin
      @(negedge clk);
      probe.glitch(g_osc, g_fl);
    end
    for (i = 0; i < 4; i++) begin
      @(negedge clk);
      check("sys_rst_n stretched", 32'h0, sys_rst_n);
    end
    for (i = 0; i < 10 && sys_rst_n !== 1'b1; i++)
      @(negedge clk);
    check("sys_rst_n released", 32'h1, sys_rst_n);
    check("reset cause", {29'h0, cause}, rst_cause);
    check("debug mode", {31'h0, ~sel}, debug_mode);
    check("periph released", {24'h0, ~periph_rst_req},
          periph_rst_n);
  endtask

  task automatic test_power_up();
    check("cause at power-up", 32'h4, rst_cause);
    check("sys_rst_n at power-up", 32'h0, sys_rst_n);
    check("source at power-up", 32'h0, system_base_clock);
    nrst = 1'b1;
    repeat (5) @(negedge clk);
    check("sys_rst_n settling", 32'h0, sys_rst_n);
    @(negedge clk);
    check("sys_rst_n after power-up", 32'h1, sys_rst_n);
    check("periph after power-up", 32'hFF, periph_rst_n);
    check("cause kept", 32'h4, rst_cause);
    $display("test power_up done");
  endtask

  task automatic test_debug_select();
    periph_rst_req = 8'hA5;
    run_reset(1'b0, 1'b0, 1'b0, 3'b010);
    probe.set_pins(4'hB, 1'b1);
    repeat (2) @(negedge clk);
    check("probe routed", 32'hB, dbg_jtag);
    check("debug tdo high", 32'h1, tdo);
    check("debug tdo enable", 32'h1, tdo_oe);
    probe.set_pins(4'hB, 1'b0);
    repeat (2) @(negedge clk);
    check("debug tdo low", 32'h0, tdo);
    probe.set_pins(4'h1, 1'b0);
    $display("test debug_select done");
  endtask

  task automatic test_stretch();
    periph_rst_req = 8'h0F;
    run_reset(1'b1, 1'b1, 1'b0, 3'b011);
    run_reset(1'b1, 1'b0, 1'b1, 3'b011);
    periph_rst_req = 8'h81;
    repeat (3) @(negedge clk);
    check("periph alone", 32'h7E, periph_rst_n);
    check("scan routing", 32'h6, dbg_jtag);
    $display("test stretch done");
  endtask

  task automatic test_idcode();
    logic        b;
    logic [31:0] word;
    int          i;
    probe.set_pins(4'h0, 1'b0);
    repeat (3) @(negedge clk);
    probe.set_pins(4'h1, 1'b0);
    probe.tck_bit(1'b0, 1'b0, b);
    probe.tck_bit(1'b1, 1'b0, b);
    probe.tck_bit(1'b0, 1'b0, b);
    probe.tck_bit(1'b0, 1'b0, b);
    for (i = 0; i < 32; i++) begin
      probe.tck_bit(1'b0, 1'b0, b);
      word[i] = b;
    end
    check("idcode", `RDS_IDCODE_VAL, word);
    check("tdo driven", 32'h1, tdo_oe);
    probe.set_pins(4'h0, 1'b0);
    repeat (4) @(negedge clk);
    check("tdo after test reset", 32'h0, tdo_oe);
    probe.set_pins(4'h1, 1'b0);
    $display("test idcode done");
  endtask

  // Clock enable low freezes the peripheral resets
  task automatic test_freeze();
    ce = 1'b0;
    periph_rst_req = 8'h3C;
    repeat (3) @(negedge clk);
    check("periph frozen", 32'h7E, periph_rst_n);
    ce = 1'b1;
    repeat (2) @(negedge clk);
    check("periph thawed", 32'hC3, periph_rst_n);
    $display("test freeze done");
  endtask

  // From test reset: load an instruction, end in Shift-DR
  task automatic scan_ir(input logic [3:0] code);
    logic       b;
    logic [3:0] cap;
    int         i;
    probe.set_pins(4'h0, 1'b0);
    probe.set_pins(4'h1, 1'b0);
    probe.tck_bit(1'b0, 1'b0, b);
    probe.tck_bit(1'b1, 1'b0, b);
    probe.tck_bit(1'b1, 1'b0, b);
    probe.tck_bit(1'b0, 1'b0, b);
    probe.tck_bit(1'b0, 1'b0, b);
    for (i = 0; i < 4; i++) begin
      probe.tck_bit(i == 3, code[i], b);
      cap[i] = b;
    end
    check("ir capture", `RDS_IR_CAPTURE, cap);
    probe.tck_bit(1'b1, 1'b0, b);
    probe.tck_bit(1'b0, 1'b0, b);
    probe.tck_bit(1'b1, 1'b0, b);
    probe.tck_bit(1'b0, 1'b0, b);
    probe.tck_bit(1'b0, 1'b0, b);
  endtask

  task automatic test_sample();
    logic       b;
    logic [7:0] pins;
    int         i;
    scan_ir(`RDS_IR_SAMPLE);
    for (i = 0; i < 8; i++) begin
      probe.tck_bit(1'b0, 1'b0, b);
      pins[i] = b;
    end
    check("sampled pins", 32'h3C, pins);
    scan_ir(`RDS_IR_BYPASS);
    probe.tck_bit(1'b0, 1'b1, b);
    check("bypass capture", 32'h0, b);
    probe.tck_bit(1'b0, 1'b0, b);
    check("bypass delay", 32'h1, b);
    $display("test sample done");
  endtask

  initial begin
    nrst = 1'b0;
    ce = 1'b1;
    periph_rst_req = 8'h00;
    bad_count = 0;
    tests_run = 0;
    repeat (6) @(negedge clk);
    test_power_up();
    test_debug_select();
    test_stretch();
    test_freeze();
    test_idcode();
    test_sample();
    stop_test();
  end
endmodule

`default_nettype wire

// ### design/rds_defines.svh
// Constants for the reset and debug-select block.
// Assumes inclusion by bare name from design and bench files.
`ifndef RDS_DEFINES_SVH
`define RDS_DEFINES_SVH

`define RDS_NUM_PERIPH   8
`define RDS_IR_W         4
`define RDS_IR_IDCODE    4'h1
`define RDS_IR_SAMPLE    4'h2
`define RDS_IR_BYPASS    4'hF
`define RDS_IR_CAPTURE   4'h1
`define RDS_IDCODE_VAL   32'h0000_0A5B  // Arbitrary value
`define RDS_BSR_W        8
`define RDS_DR_W         32
`define RDS_SETTLE_CYC   4'h3
`define RDS_SETTLE_W     4

`endif

// ### design/rds_pkg.sv
// Types shared by the reset and debug-select block.
// Assumes rds_defines.svh is on the include path.
`include "rds_defines.svh"

package rds_pkg;

  typedef enum logic {
    RDS_CLK_RING_OSC,
    RDS_CLK_CRYSTAL
  } rds_clk_src_e;

  typedef enum logic [1:0] {
    RDS_ST_HOLD,
    RDS_ST_WAIT,
    RDS_ST_RUN
  } rds_state_e;

  typedef enum logic [3:0] {
    RDS_TAP_RESET, RDS_TAP_IDLE, RDS_TAP_SEL_DR, RDS_TAP_CAP_DR,
    RDS_TAP_SH_DR, RDS_TAP_EX1_DR, RDS_TAP_PAU_DR, RDS_TAP_EX2_DR,
    RDS_TAP_UPD_DR, RDS_TAP_SEL_IR, RDS_TAP_CAP_IR, RDS_TAP_SH_IR,
    RDS_TAP_EX1_IR, RDS_TAP_PAU_IR, RDS_TAP_EX2_IR, RDS_TAP_UPD_IR
  } rds_tap_e;

  // Origin of the most recent reset
  typedef struct packed {
    logic power_up;
    logic external;
    logic stretched;
  } rds_cause_s;

  // Test access port pins as seen by the block
  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
    logic trst_n;
  } rds_jtag_s;

  typedef logic [`RDS_NUM_PERIPH-1:0] rds_periph_t;

endpackage

// ### design/rds_tap.sv
// Boundary-scan test access port with IDCODE, SAMPLE and BYPASS.
// Assumes TCK and friends are synchronous to clk; TCK edges are found here.
`timescale 1ns/1ps
`default_nettype none
`include "rds_defines.svh"

module rds_tap (
  input  wire logic                     clk,
  input  wire logic                     nrst,
  input  wire logic                     ce,
  input  wire rds_pkg::rds_jtag_s       jtag,
  input  wire logic [`RDS_BSR_W-1:0]    bscan_in,
  output logic                          tdo,
  output logic                          tdo_oe,
  output logic                          tck_rise
);

  rds_pkg::rds_tap_e           st_q;
  logic                        tck_q;
  logic                        tck_fall;
  logic [`RDS_IR_W-1:0]        ir_q;
  logic [`RDS_IR_W-1:0]        irsh_q;
  logic [`RDS_DR_W-1:0]        dr_q;

  function automatic rds_pkg::rds_tap_e next_st(rds_pkg::rds_tap_e s,
                                                 logic m);
    unique case (s)
      rds_pkg::RDS_TAP_RESET:  next_st = m ? s : rds_pkg::RDS_TAP_IDLE;
      rds_pkg::RDS_TAP_IDLE:   next_st = m ? rds_pkg::RDS_TAP_SEL_DR : s;
      rds_pkg::RDS_TAP_SEL_DR: next_st = m ? rds_pkg::RDS_TAP_SEL_IR
                                           : rds_pkg::RDS_TAP_CAP_DR;
      rds_pkg::RDS_TAP_CAP_DR,
      rds_pkg::RDS_TAP_SH_DR:  next_st = m ? rds_pkg::RDS_TAP_EX1_DR
                                           : rds_pkg::RDS_TAP_SH_DR;
      rds_pkg::RDS_TAP_EX1_DR: next_st = m ? rds_pkg::RDS_TAP_UPD_DR
                                           : rds_pkg::RDS_TAP_PAU_DR;
      rds_pkg::RDS_TAP_PAU_DR: next_st = m ? rds_pkg::RDS_TAP_EX2_DR : s;
      rds_pkg::RDS_TAP_EX2_DR: next_st = m ? rds_pkg::RDS_TAP_UPD_DR
                                           : rds_pkg::RDS_TAP_SH_DR;
      rds_pkg::RDS_TAP_UPD_DR,
      rds_pkg::RDS_TAP_UPD_IR: next_st = m ? rds_pkg::RDS_TAP_SEL_DR
                                           : rds_pkg::RDS_TAP_IDLE;
      rds_pkg::RDS_TAP_SEL_IR: next_st = m ? rds_pkg::RDS_TAP_RESET
                                           : rds_pkg::RDS_TAP_CAP_IR;
      rds_pkg::RDS_TAP_CAP_IR,
      rds_pkg::RDS_TAP_SH_IR:  next_st = m ? rds_pkg::RDS_TAP_EX1_IR
                                           : rds_pkg::RDS_TAP_SH_IR;
      rds_pkg::RDS_TAP_EX1_IR: next_st = m ? rds_pkg::RDS_TAP_UPD_IR
                                           : rds_pkg::RDS_TAP_PAU_IR;
      rds_pkg::RDS_TAP_PAU_IR: next_st = m ? rds_pkg::RDS_TAP_EX2_IR : s;
      rds_pkg::RDS_TAP_EX2_IR: next_st = m ? rds_pkg::RDS_TAP_UPD_IR
                                           : rds_pkg::RDS_TAP_SH_IR;
    endcase
  endfunction

  assign tck_rise = jtag.tck & ~tck_q;
  assign tck_fall = ~jtag.tck & tck_q;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tck_q <= 1'b0;
    end else if (ce) begin
      tck_q <= jtag.tck;
    end
  end

  // Controller; test reset is active low
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_q <= rds_pkg::RDS_TAP_RESET;
    end else if (ce) begin
      if (!jtag.trst_n) begin
        st_q <= rds_pkg::RDS_TAP_RESET;
      end else if (tck_rise) begin
        st_q <= next_st(st_q, jtag.tms);
      end
    end
  end

  // Instruction and data registers
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ir_q   <= `RDS_IR_IDCODE;
      irsh_q <= '0;
      dr_q   <= '0;
    end else if (ce) begin
      if (!jtag.trst_n || st_q == rds_pkg::RDS_TAP_RESET) begin
        ir_q <= `RDS_IR_IDCODE;
      end else if (tck_rise) begin
        unique case (st_q)
          rds_pkg::RDS_TAP_CAP_IR: irsh_q <= `RDS_IR_CAPTURE;
          rds_pkg::RDS_TAP_SH_IR:  irsh_q <= {jtag.tdi, irsh_q[`RDS_IR_W-1:1]};
          rds_pkg::RDS_TAP_UPD_IR: ir_q   <= irsh_q;
          rds_pkg::RDS_TAP_CAP_DR: begin
            if (ir_q == `RDS_IR_IDCODE) begin
              dr_q <= `RDS_IDCODE_VAL;
            end else if (ir_q == `RDS_IR_SAMPLE) begin
              dr_q <= {{(`RDS_DR_W-`RDS_BSR_W){1'b0}}, bscan_in};
            end else begin
              dr_q <= '0;
            end
          end
          rds_pkg::RDS_TAP_SH_DR: begin
            if (ir_q == `RDS_IR_IDCODE) begin
              dr_q <= {jtag.tdi, dr_q[`RDS_DR_W-1:1]};
            end else if (ir_q == `RDS_IR_SAMPLE) begin
              dr_q <= {{(`RDS_DR_W-`RDS_BSR_W){1'b0}}, jtag.tdi,
                       dr_q[`RDS_BSR_W-1:1]};
            end else begin
              dr_q <= {{(`RDS_DR_W-1){1'b0}}, jtag.tdi};
            end
          end
          default: ;
        endcase
      end
    end
  end

  // Output changes on the falling test clock; off in test reset
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tdo    <= 1'b0;
      tdo_oe <= 1'b0;
    end else if (ce) begin
      if (!jtag.trst_n) begin
        tdo_oe <= 1'b0;
      end else if (tck_fall) begin
        tdo_oe <= (st_q == rds_pkg::RDS_TAP_SH_DR) ||
                  (st_q == rds_pkg::RDS_TAP_SH_IR);
        tdo    <= (st_q == rds_pkg::RDS_TAP_SH_IR) ? irsh_q[0] : dr_q[0];
      end
    end
  end

  trst_oe_off_a: assert property (
    @(posedge clk) disable iff (!nrst) ce && !jtag.trst_n |=> !tdo_oe)
    else $error("test data out driven during test reset");

endmodule

`default_nettype wire

// ### design/rds_top.sv
// Reset entry, reset stretching, debug select and reset generator.
// Assumes all pins synchronous to clk; nrst is the power-up reset.
// How it works
// - External reset pin is active low; low puts chip in reset.
// - Internal reset held until oscillators and flash both report stable.
// - Select low during external reset picks crystal as system clock.
// - Select low routes test port to debug; high to boundary scan.
// - Standard boundary-scan port with clock, mode, data in/out, reset.
// - Test reset input is active low and resets test logic.
// - Generator drives each peripheral reset, each controllable alone.
// - Generator records the source of the most recent reset.
`timescale 1ns/1ps
`default_nettype none
`include "rds_defines.svh"

module rds_top (
  input  wire logic                     clk,
  input  wire logic                     nrst,
  input  wire logic                     ce,
  input  wire logic                     ext_rst_n,
  input  wire logic                     osc_stable,
  input  wire logic                     flash_stable,
  input  wire logic                     tap_function_select,
  input  wire rds_pkg::rds_periph_t     periph_rst_req,
  input  wire rds_pkg::rds_jtag_s       jtag,
  input  wire logic                     dbg_tdo,
  input  wire logic                     dbg_tdo_oe,
  input  wire logic [`RDS_BSR_W-1:0]    bscan_in,
  output logic                          sys_rst_n,
  output rds_pkg::rds_periph_t          periph_rst_n,
  output rds_pkg::rds_cause_s           rst_cause,
  output rds_pkg::rds_clk_src_e         system_base_clock,
  output logic                          debug_mode,
  output rds_pkg::rds_jtag_s            dbg_jtag,
  output logic                          tdo,
  output logic                          tdo_oe
);

  rds_pkg::rds_state_e            st_q;
  logic [`RDS_SETTLE_W-1:0]       settle_q;
  logic                           ext_q;
  logic                           tap_tdo;
  logic                           tap_tdo_oe;
  logic                           both_stable;
  logic                           ext_entry;
  rds_pkg::rds_jtag_s             park_jtag;
  rds_pkg::rds_jtag_s             tap_jtag;

  assign both_stable = osc_stable & flash_stable;
  assign ext_entry   = ~ext_rst_n & ext_q;

  // Previous external pin level for entry detection
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ext_q <= 1'b1;
    end else if (ce) begin
      ext_q <= ext_rst_n;
    end
  end

  // Reset sequencer
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_q <= rds_pkg::RDS_ST_HOLD;
    end else if (ce) begin
      if (!ext_rst_n) begin
        st_q <= rds_pkg::RDS_ST_HOLD;
      end else begin
        unique case (st_q)
          rds_pkg::RDS_ST_HOLD: st_q <= rds_pkg::RDS_ST_WAIT;
          rds_pkg::RDS_ST_WAIT: begin
            if (both_stable && settle_q == `RDS_SETTLE_CYC) begin
              st_q <= rds_pkg::RDS_ST_RUN;
            end
          end
          rds_pkg::RDS_ST_RUN:  st_q <= rds_pkg::RDS_ST_RUN;
        endcase
      end
    end
  end

  // Both must stay stable for a few cycles
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      settle_q <= '0;
    end else if (ce) begin
      if (st_q != rds_pkg::RDS_ST_WAIT || !both_stable) begin
        settle_q <= '0;
      end else if (settle_q != `RDS_SETTLE_CYC) begin
        settle_q <= settle_q + 1'b1;
      end
    end
  end

  // Released only after stable
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sys_rst_n <= 1'b0;
    end else if (ce) begin
      sys_rst_n <= (st_q == rds_pkg::RDS_ST_RUN) && ext_rst_n;
    end
  end

  // Per-peripheral resets, each individually forced
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      periph_rst_n <= '0;
    end else if (ce) begin
      periph_rst_n <= (st_q == rds_pkg::RDS_ST_RUN && ext_rst_n) ?
                      ~periph_rst_req : '0;
    end
  end

  // Reset origin record
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rst_cause <= '{power_up: 1'b1, external: 1'b0, stretched: 1'b0};
    end else if (ce) begin
      if (ext_entry) begin
        rst_cause <= '{power_up: 1'b0, external: 1'b1, stretched: 1'b0};
      end else if (st_q == rds_pkg::RDS_ST_WAIT && !both_stable) begin
        rst_cause.stretched <= 1'b1;
      end
    end
  end

  // Select sampled while external reset is applied
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      system_base_clock <= rds_pkg::RDS_CLK_RING_OSC;
    end else if (ce && !ext_rst_n) begin
      system_base_clock <= tap_function_select ? rds_pkg::RDS_CLK_RING_OSC
                                               : rds_pkg::RDS_CLK_CRYSTAL;
    end
  end

  // Test port routing follows the select level
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      debug_mode <= 1'b0;
    end else if (ce) begin
      debug_mode <= ~tap_function_select;
    end
  end

  // Idle levels for whichever side is not selected
  assign park_jtag = '{tck: 1'b0, tms: 1'b1, tdi: 1'b1, trst_n: 1'b0};
  assign dbg_jtag  = debug_mode ? jtag : park_jtag;
  assign tap_jtag  = debug_mode ? park_jtag : jtag;

  rds_tap u_tap (
    .clk      (clk),
    .nrst     (nrst),
    .ce       (ce),
    .jtag     (tap_jtag),
    .bscan_in (bscan_in),
    .tdo      (tap_tdo),
    .tdo_oe   (tap_tdo_oe),
    .tck_rise ()
  );

  // Data-out mux between debug chain and scan
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tdo    <= 1'b0;
      tdo_oe <= 1'b0;
    end else if (ce) begin
      tdo    <= debug_mode ? dbg_tdo : tap_tdo;
      tdo_oe <= debug_mode ? dbg_tdo_oe : tap_tdo_oe;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  sequence ext_pulse_s;
    ce && !ext_rst_n;
  endsequence

  sequence stable_run_s;
    ce && st_q == rds_pkg::RDS_ST_WAIT && both_stable &&
    settle_q == `RDS_SETTLE_CYC && ext_rst_n;
  endsequence

  ext_holds_rst_a: assert property (
    ext_pulse_s |=> !sys_rst_n)
    else $error("system reset released while external reset low");

  no_early_rel_a: assert property (
    ce && $rose(sys_rst_n) |-> $past(st_q) == rds_pkg::RDS_ST_WAIT ||
                               $past(st_q) == rds_pkg::RDS_ST_RUN)
    else $error("system reset released before sequencer ran");

  stable_release_a: assert property (
    stable_run_s ##1 (ce && ext_rst_n) |=> sys_rst_n)
    else $error("system reset not released after stable");

  unstable_hold_a: assert property (
    ce && st_q == rds_pkg::RDS_ST_WAIT && !both_stable |=> !sys_rst_n)
    else $error("system reset released while sources unstable");

  crystal_sel_a: assert property (
    (ext_pulse_s and !tap_function_select)
      |=> system_base_clock == rds_pkg::RDS_CLK_CRYSTAL)
    else $error("crystal not chosen for debug select");

  ring_sel_a: assert property (
    (ext_pulse_s and tap_function_select)
      |=> system_base_clock == rds_pkg::RDS_CLK_RING_OSC)
    else $error("ring oscillator not kept");

  clk_src_hold_a: assert property (
    ce && ext_rst_n |=> $stable(system_base_clock))
    else $error("clock source changed outside reset");

  debug_route_a: assert property (
    ce && !tap_function_select ##1 ce && !tap_function_select
      |-> ##1 (tdo == $past(dbg_tdo) && debug_mode))
    else $error("debug chain not routed to data out");

  periph_ctrl_a: assert property (
    ce && st_q == rds_pkg::RDS_ST_RUN && ext_rst_n
      |=> periph_rst_n == ~$past(periph_rst_req))
    else $error("peripheral reset not individually controlled");

  periph_in_rst_a: assert property (
    !sys_rst_n |-> periph_rst_n == '0)
    else $error("peripheral out of reset during system reset");

  cause_ext_a: assert property (
    ce && ext_entry |=> rst_cause.external && !rst_cause.power_up)
    else $error("external reset origin not recorded");

endmodule

`default_nettype wire
